//--- hdl/fgs_regs.svh
`ifndef FGS_REGS_SVH
`define FGS_REGS_SVH

// Register bus geometry
`define FGS_ADDR_W 4
`define FGS_DATA_W 32
`define FGS_CNT_W 32

// Register byte offsets
`define FGS_OFF_CTRL 4'h0
`define FGS_OFF_SRC 4'h4
`define FGS_OFF_STAT 4'h8
`define FGS_OFF_COUNT 4'hc

// Control register fields
`define FGS_CTRL_INT_GATEN 0
`define FGS_CTRL_GATE_DRIVE 1
`define FGS_CTRL_ARM_INT 2
`define FGS_CTRL_PAR_HOFF 3
`define FGS_CTRL_SINGLE_EDGE_N 4
`define FGS_CTRL_FREQ_MODE 5
`define FGS_CTRL_W 6
`define FGS_CTRL_RST 6'h11

// Source select fields, three bits each
`define FGS_SRC_FREQ_LSB 0
`define FGS_SRC_START_LSB 3
`define FGS_SRC_STOP_LSB 6
`define FGS_SRC_W 9
`define FGS_SRC_RST 9'h000

// Status register fields
`define FGS_STAT_LATCH_LSB 0
`define FGS_STAT_MODE_LSB 8
`define FGS_STAT_PHASE_LSB 12

`endif

//--- hdl/fgs_pkg.sv
package fgs_pkg;

  // Source codes of the start, stop and frequency selectors
  typedef enum logic [2:0] {
    FGS_SRC_A,
    FGS_SRC_A_INV,
    FGS_SRC_B,
    FGS_SRC_B_INV,
    FGS_SRC_CAL
  } fgs_src_t;

  // Gating modes as decoded from the control bits
  typedef enum logic [1:0] {
    FGS_MODE_FIXED,
    FGS_MODE_EXT_TRIG,
    FGS_MODE_EXT_GATE,
    FGS_MODE_SINGLE
  } fgs_mode_t;

  // Measurement phase
  typedef enum logic [1:0] {
    FGS_PH_IDLE,
    FGS_PH_ARMED,
    FGS_PH_COUNT,
    FGS_PH_DONE
  } fgs_phase_t;

endpackage

//--- hdl/fgs_gate_sync.sv
`timescale 1ns/1ps
`include "fgs_regs.svh"
// Summary of operation
// - Start on second source edge after gate opens
// - Stop on second rising edge after gate falls
// - Cycle window opens when start is set
// - Stop feeds interval stop, closes cycle window
// - Single edge mode: first edge starts, stops
// - Three gating modes decoded: fixed, external gate, single
// - Self armed single period: three edges
// - External input passes XOR when gate select low
// - External gate opens on XOR edges, closes on them only with holdoff set
// - At least one full source cycle measured
// - Single edge mode bypasses first sync stage
// - Nine select bits pick A, B, polarity, cal
// - Frequency mode routes gate pulses to interval counter
// - Polarity chosen by inverted or true comparator
// - Lower channel counts source inside cycle window
module fgs_gate_sync (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [`FGS_ADDR_W-1:0] addr_i,
  input wire logic [`FGS_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`FGS_DATA_W-1:0] rdata_o,
  input wire logic in_a_i,
  input wire logic in_a_n_i,
  input wire logic in_b_i,
  input wire logic in_b_n_i,
  input wire logic cal_1khz_i,
  input wire logic external_input_discriminated_i,
  input wire logic load_i,
  output logic freq_start_o,
  output logic freq_stop_o,
  output logic freq_gate_o,
  output logic ti_start_o,
  output logic ti_stop_o,
  output logic freq_src_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  localparam int NSYNC = 7;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;

  // Order: a, a_n, b, b_n, cal, ext, load
  assign pin_raw = {load_i, external_input_discriminated_i, cal_1khz_i,
                    in_b_n_i, in_b_i, in_a_n_i, in_a_i};

  // Two flops per pin; the first one is read only by the second
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= pin_raw[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  logic ext_s;
  logic load_s;
  assign ext_s = sync_q[5];
  assign load_s = sync_q[6];

  ////////////////////////////////////////////////////////////////////////////
  // Source selection

  // Complementary comparator outputs give rising or falling edge trigger
  function automatic logic src_pick(input logic [2:0] sel, input logic [4:0] srcs);
    case (sel)
      fgs_pkg::FGS_SRC_A: src_pick = srcs[0];
      fgs_pkg::FGS_SRC_A_INV: src_pick = srcs[1];
      fgs_pkg::FGS_SRC_B: src_pick = srcs[2];
      fgs_pkg::FGS_SRC_B_INV: src_pick = srcs[3];
      fgs_pkg::FGS_SRC_CAL: src_pick = srcs[4];
      default: src_pick = 1'b0;
    endcase
  endfunction

  // Decode of the gating mode from the loose control bits
  function automatic fgs_pkg::fgs_mode_t mode_of(input logic [`FGS_CTRL_W-1:0] c);
    if (c[`FGS_CTRL_ARM_INT])
      mode_of = fgs_pkg::FGS_MODE_SINGLE;
    else if (!c[`FGS_CTRL_INT_GATEN])
      mode_of = fgs_pkg::FGS_MODE_EXT_GATE;
    else
      mode_of = fgs_pkg::FGS_MODE_FIXED;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [`FGS_CTRL_W-1:0] ctrl_q;
  logic [`FGS_SRC_W-1:0] src_q;
  logic [`FGS_CNT_W-1:0] cnt_q;

  // Control and source select writes
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ctrl_q <= `FGS_CTRL_RST;
      src_q <= `FGS_SRC_RST;
    end else if (wr_i) begin
      if (addr_i == `FGS_OFF_CTRL) begin
        ctrl_q <= wdata_i[`FGS_CTRL_W-1:0];
      end
      if (addr_i == `FGS_OFF_SRC) begin
        src_q <= wdata_i[`FGS_SRC_W-1:0];
      end
    end
  end

  logic int_gaten;
  logic gate_drive;
  logic arm_int;
  logic par_hoff;
  logic single_edge_n;
  logic freq_mode;
  assign int_gaten = ctrl_q[`FGS_CTRL_INT_GATEN];
  assign gate_drive = ctrl_q[`FGS_CTRL_GATE_DRIVE];
  assign arm_int = ctrl_q[`FGS_CTRL_ARM_INT];
  assign par_hoff = ctrl_q[`FGS_CTRL_PAR_HOFF];
  assign single_edge_n = ctrl_q[`FGS_CTRL_SINGLE_EDGE_N];
  assign freq_mode = ctrl_q[`FGS_CTRL_FREQ_MODE];

  logic [4:0] srcs;
  logic freq_src;
  logic start_src;
  logic stop_src;
  assign srcs = sync_q[4:0];
  assign freq_src = src_pick(src_q[`FGS_SRC_FREQ_LSB +: 3], srcs);
  assign start_src = src_pick(src_q[`FGS_SRC_START_LSB +: 3], srcs);
  assign stop_src = src_pick(src_q[`FGS_SRC_STOP_LSB +: 3], srcs);

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection

  logic src_prev_q;
  logic gate_prev_q;
  logic load_prev_q;
  logic gate_sig;

  // Internal gate follows the drive bit; external passes the XOR
  assign gate_sig = int_gaten ? gate_drive
                              : (ext_s ^ gate_drive);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      src_prev_q <= 1'b0;
      gate_prev_q <= 1'b0;
      load_prev_q <= 1'b0;
    end else begin
      src_prev_q <= freq_src;
      gate_prev_q <= gate_sig;
      load_prev_q <= load_s;
    end
  end

  logic src_rise;
  logic gate_open;
  logic gate_close;
  logic load_end;
  assign src_rise = freq_src & ~src_prev_q;
  // Rise of the true XOR output opens, rise of the inverted one closes
  assign gate_open = gate_sig & ~gate_prev_q;
  assign gate_close = ~gate_sig & gate_prev_q;
  assign load_end = ~load_s & load_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Gate latches

  logic en_a_q;
  logic en_b_q;
  logic self_arm;
  logic close_now;

  // Self arming on load end, forced when the first stage is bypassed
  assign self_arm = load_end & (arm_int | ~single_edge_n);
  // With external gating and no holdoff the stop latch follows the start latch
  assign close_now = int_gaten ? gate_close
                               : (par_hoff ? gate_close : en_a_q);

  always_ff @(posedge core_clk_i) begin
    if (srst_i || load_s) begin
      en_a_q <= 1'b0;
      en_b_q <= 1'b0;
    end else begin
      if (self_arm || (!arm_int && gate_open)) begin
        en_a_q <= 1'b1;
      end
      // Close is only honoured once the gate is open
      if (self_arm || (!arm_int && en_a_q && close_now)) begin
        en_b_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisation stages

  logic s1a_q;
  logic s1b_q;
  logic start_q;
  logic stop_q;
  logic stage_a;
  logic stage_b;

  // In single edge mode the first stage is skipped
  assign stage_a = single_edge_n ? s1a_q : en_a_q;
  assign stage_b = single_edge_n ? s1b_q : en_b_q;

  // First stage: one source edge after the latch
  always_ff @(posedge core_clk_i) begin
    if (srst_i || load_s) begin
      s1a_q <= 1'b0;
      s1b_q <= 1'b0;
    end else if (src_rise) begin
      if (en_a_q) begin
        s1a_q <= 1'b1;
      end
      // Stop stage is held in reset until the start stage is set
      if (en_b_q && s1a_q) begin
        s1b_q <= 1'b1;
      end
    end
  end

  // Second stage: start, then stop, never on the same edge
  always_ff @(posedge core_clk_i) begin
    if (srst_i || load_s) begin
      start_q <= 1'b0;
      stop_q <= 1'b0;
    end else if (src_rise) begin
      if (stage_a) begin
        start_q <= 1'b1;
      end
      // Stop needs start already set, so a whole cycle lies between
      if (stage_b && start_q) begin
        stop_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle window and lower counting channel

  logic gate_win;
  assign gate_win = start_q & ~stop_q;

  // Counts source edges inside the window; load clears it
  always_ff @(posedge core_clk_i) begin
    if (srst_i || load_s) begin
      cnt_q <= '0;
    end else if (gate_win && src_rise) begin
      cnt_q <= cnt_q + `FGS_CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase tracking

  fgs_pkg::fgs_phase_t phase_q;

  always_ff @(posedge core_clk_i) begin
    if (srst_i || load_s) begin
      phase_q <= fgs_pkg::FGS_PH_IDLE;
    end else begin
      case (phase_q)
        fgs_pkg::FGS_PH_IDLE: begin
          if (en_a_q) begin
            phase_q <= fgs_pkg::FGS_PH_ARMED;
          end
        end
        fgs_pkg::FGS_PH_ARMED: begin
          if (start_q) begin
            phase_q <= fgs_pkg::FGS_PH_COUNT;
          end
        end
        fgs_pkg::FGS_PH_COUNT: begin
          if (stop_q) begin
            phase_q <= fgs_pkg::FGS_PH_DONE;
          end
        end
        fgs_pkg::FGS_PH_DONE: begin
          phase_q <= fgs_pkg::FGS_PH_DONE;
        end
        default: phase_q <= fgs_pkg::FGS_PH_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all registered

  // Registering costs one cycle but keeps the outputs glitch free
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      freq_start_o <= 1'b0;
      freq_stop_o <= 1'b0;
      freq_gate_o <= 1'b0;
      ti_start_o <= 1'b0;
      ti_stop_o <= 1'b0;
      freq_src_o <= 1'b0;
    end else begin
      freq_start_o <= start_q;
      freq_stop_o <= stop_q;
      freq_gate_o <= gate_win;
      ti_start_o <= freq_mode ? start_q : start_src;
      ti_stop_o <= freq_mode ? stop_q : stop_src;
      freq_src_o <= freq_src;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  logic [`FGS_DATA_W-1:0] stat_word;
  fgs_pkg::fgs_mode_t mode_now;

  // Fixed and delayed gates differ only in the drive bit timing
  assign mode_now = mode_of(ctrl_q);

  always_comb begin
    stat_word = '0;
    stat_word[`FGS_STAT_LATCH_LSB +: 7] = {gate_win, stop_q, start_q, s1b_q, s1a_q,
                                           en_b_q, en_a_q};
    stat_word[`FGS_STAT_MODE_LSB +: 2] = mode_now;
    stat_word[`FGS_STAT_PHASE_LSB +: 2] = phase_q;
  end

  // Data stand in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      case (addr_i)
        `FGS_OFF_CTRL: rdata_o <= {{(`FGS_DATA_W-`FGS_CTRL_W){1'b0}}, ctrl_q};
        `FGS_OFF_SRC: rdata_o <= {{(`FGS_DATA_W-`FGS_SRC_W){1'b0}}, src_q};
        `FGS_OFF_STAT: rdata_o <= stat_word;
        `FGS_OFF_COUNT: rdata_o <= cnt_q;
        default: rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

endmodule // fgs_gate_sync

//--- bench/fgs_gate_sync_checker.sv
`timescale 1ns/1ps
`include "fgs_regs.svh"
////////////////////////////////////////////////////////////
// Timing relations among the gate outputs, load and the read port
module fgs_gate_sync_checker (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic rd_i,
  input wire logic [`FGS_DATA_W-1:0] rdata_o,
  input wire logic load_i,
  input wire logic freq_start_o,
  input wire logic freq_stop_o,
  input wire logic freq_gate_o
);
  // Single clock domain, so one default for all properties
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  property p_stop_after_start; $rose(freq_stop_o) |-> freq_start_o; endproperty
  a_stop_after_start: assert property (p_stop_after_start)
    else $error("stop set without start");
  // Window opens with start; the check allows one cycle of slack
  property p_win_open; $rose(freq_start_o) |-> ##[0:1] (freq_gate_o || freq_stop_o); endproperty
  a_win_open: assert property (p_win_open)
    else $error("window did not open after start");
  property p_win_cause; $rose(freq_gate_o) |-> freq_start_o; endproperty
  a_win_cause: assert property (p_win_cause)
    else $error("window opened without start");
  property p_win_close; $rose(freq_stop_o) |=> !freq_gate_o; endproperty
  a_win_close: assert property (p_win_close)
    else $error("window still open after stop");
  // Load passes a two-flop synchroniser before it clears
  property p_load_clr; load_i [*5] |=> !(freq_start_o || freq_stop_o || freq_gate_o); endproperty
  a_load_clr: assert property (p_load_clr)
    else $error("load did not clear the latches");
  property p_start_hold;
    $fell(freq_start_o) |-> $past(load_i, 2) || $past(load_i, 3) || $past(load_i, 4);
  endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("start dropped without load");
  property p_stop_hold;
    $fell(freq_stop_o) |-> $past(load_i, 2) || $past(load_i, 3) || $past(load_i, 4);
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("stop dropped without load");
  property p_rd_idle; !$past(rd_i) |-> rdata_o == '0; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its cycle");
endmodule // fgs_gate_sync_checker

bind fgs_gate_sync fgs_gate_sync_checker u_chk (
  .core_clk_i(core_clk_i),
  .srst_i(srst_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .load_i(load_i),
  .freq_start_o(freq_start_o),
  .freq_stop_o(freq_stop_o),
  .freq_gate_o(freq_gate_o)
);

//--- bench/fgs_front_end_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Input comparators; levels come from the bench scenarios
module fgs_front_end_model (
  input wire logic a_lvl_i,
  input wire logic b_lvl_i,
  input wire logic cal_lvl_i,
  input wire logic ext_lvl_i,
  output logic in_a_o,
  output logic in_a_n_o,
  output logic in_b_o,
  output logic in_b_n_o,
  output logic cal_o,
  output logic ext_o
);
  // True and inverted copies let the selectors pick either edge
  assign in_a_o = a_lvl_i;
  assign in_a_n_o = ~a_lvl_i;
  assign in_b_o = b_lvl_i;
  assign in_b_n_o = ~b_lvl_i;
  // Calibration level passes straight through from the bench
  assign cal_o = cal_lvl_i;
  assign ext_o = ext_lvl_i;
endmodule // fgs_front_end_model

//--- bench/frequency_gate_sync_bench.sv
`timescale 1ns/1ps
`include "fgs_regs.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
  $display("ERROR %0t ns: got %h want %h", $time, (a), (b)); end end
////////////////////////////////////////////////////////////
module frequency_gate_sync_bench;
  logic core_clk_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, load_i = 0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic [31:0] rdata_o;
  logic a_lvl = 0, b_lvl = 0, cal_lvl = 0, ext_lvl = 0;
  logic in_a, in_a_n, in_b, in_b_n, cal, ext;
  logic freq_start_o, freq_stop_o, freq_gate_o, ti_start_o, ti_stop_o, freq_src_o;
  int errors = 0, num_checks = 0;

  // 100 MHz core clock
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end

  fgs_front_end_model u_fe (.a_lvl_i(a_lvl), .b_lvl_i(b_lvl), .cal_lvl_i(cal_lvl),
    .ext_lvl_i(ext_lvl), .in_a_o(in_a), .in_a_n_o(in_a_n), .in_b_o(in_b),
    .in_b_n_o(in_b_n), .cal_o(cal), .ext_o(ext));

  fgs_gate_sync dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .in_a_i(in_a),
    .in_a_n_i(in_a_n), .in_b_i(in_b), .in_b_n_i(in_b_n), .cal_1khz_i(cal),
    .external_input_discriminated_i(ext), .load_i(load_i), .freq_start_o(freq_start_o),
    .freq_stop_o(freq_stop_o), .freq_gate_o(freq_gate_o), .ti_start_o(ti_start_o),
    .ti_stop_o(ti_stop_o), .freq_src_o(freq_src_o));

  ////////////////////////////////////////////////////////////
  task tally_and_finish;
    if (errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask

  // Data is looked at only in the cycle after the strobe
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 `CHK(rdata_o, e)
  endtask

  // Long enough for the load synchroniser to flush both ways
  task pulse_load;
    @(posedge core_clk_i);
    load_i <= 1'b1;
    tick(5);
    load_i <= 1'b0;
    tick(4);
  endtask

  // Source cycles spaced four core cycles per phase
  task cyc(input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      a_lvl <= 1'b1;
      tick(4);
      a_lvl <= 1'b0;
      tick(3);
    end
  endtask

  task ex(input logic s, input logic t);
    `CHK(freq_start_o, s)
    `CHK(freq_stop_o, t)
    `CHK(freq_gate_o, s & ~t)
  endtask

  // Pin pattern is a = p, b = ~p, cal = ~p; unused codes give a low source
  function automatic logic pick(input logic [2:0] c, input logic p);
    case (c)
      3'h0: return p;
      3'h1: return ~p;
      3'h2: return ~p;
      3'h3: return p;
      3'h4: return ~p;
      default: return 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////
  task t_regs;
    rd(4'h0, {26'h0, `FGS_CTRL_RST});
    wr(4'h4, 32'h0a1);
    rd(4'h4, 32'h0a1);
    rd(4'h2, 32'h0);
  endtask

  // All nine select bits, codes 0 to 5, both pin levels
  task t_select;
    logic [2:0] c;
    logic p;
    for (int i = 0; i < 6; i++) begin
      c = i[2:0];
      wr(4'h4, {23'h0, c, c, c});
      for (int j = 0; j < 2; j++) begin
        p = j[0];
        @(posedge core_clk_i);
        a_lvl <= p;
        b_lvl <= ~p;
        cal_lvl <= ~p;
        tick(6);
        `CHK(freq_src_o, pick(c, p))
        `CHK(ti_start_o, pick(c, p))
        `CHK(ti_stop_o, pick(c, p))
      end
    end
    @(posedge core_clk_i);
    a_lvl <= 1'b0;
    b_lvl <= 1'b0;
    cal_lvl <= 1'b0;
    wr(4'h4, 32'h0);
  endtask

  task t_internal;
    wr(4'h0, 32'h31);
    pulse_load;
    cyc(2);
    ex(1'b0, 1'b0);
    wr(4'h0, 32'h33);
    cyc(1);
    ex(1'b0, 1'b0);
    cyc(1);
    ex(1'b1, 1'b0);
    `CHK(ti_start_o, 1'b1)
    wr(4'h0, 32'h31);
    cyc(1);
    ex(1'b1, 1'b0);
    cyc(1);
    ex(1'b1, 1'b1);
    `CHK(ti_stop_o, 1'b1)
    // Start on edge two, stop two edges later: two whole cycles counted
    rd(4'hc, 32'h2);
    // Every latch bit set, window shut, fixed gate mode, done phase
    rd(4'h8, 32'h303f);
  endtask

  // Self-armed runs: start on edge ns, stop on the next one
  task t_self(input logic [31:0] ctrl, input int ns);
    wr(4'h0, ctrl);
    pulse_load;
    for (int i = 1; i <= ns + 1; i++) begin
      cyc(1);
      ex(i >= ns, i > ns);
    end
    // Start to stop spans exactly one source cycle
    rd(4'hc, 32'h1);
  endtask

  // A gate half as wide as one source cycle, either polarity
  task t_ext(input logic gd);
    @(posedge core_clk_i);
    ext_lvl <= gd;
    wr(4'h0, 32'h38 | {30'h0, gd, 1'b0});
    pulse_load;
    cyc(2);
    ex(1'b0, 1'b0);
    @(posedge core_clk_i);
    ext_lvl <= ~gd;
    tick(4);
    ext_lvl <= gd;
    cyc(2);
    ex(1'b1, 1'b0);
    cyc(2);
    ex(1'b1, 1'b1);
    // Narrow gate still yields one whole counted cycle
    rd(4'hc, 32'h1);
    // Every latch bit set, window shut, external gate mode, done phase
    rd(4'h8, 32'h323f);
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    tick(6);
    srst_i <= 1'b0;
    t_regs;
    t_select;
    t_internal;
    t_self(32'h35, 2);
    t_self(32'h20, 1);
    t_ext(1'b0);
    t_ext(1'b1);
    tally_and_finish;
  end

  // Hang guard: a bounded run counts as a mismatch when it expires
  initial begin
    tick(20000);
    errors++;
    tally_and_finish;
  end
endmodule // frequency_gate_sync_bench
